//--- hw/pllcm_config.sv
// Purpose: Command registers and mode selection of a dual-PLL clock synthesizer
// Assumes: 200 MHz CLK; pins asynchronous to it; analog PLLs sit outside
// Notes:   Decoded controls are registered, one cycle after the register file
`timescale 1ns/1ps
`default_nettype none
module pllcm_config (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        MASTER_SELECT,
  input  wire logic        SCS_N,
  input  wire logic        SCLK,
  input  wire logic        SDI,
  output logic             SDO,
  output logic             SDO_OE,
  output logic             MASTER_MODE,
  output logic             REF_DIVIDE_ENABLE,
  output logic             HIGH_SPEED_REVERSE,
  output logic             T1_TO_E1_SETUP,
  output logic             PLL_ONE_ENABLE,
  output logic             PLL_TWO_ENABLE,
  output logic             SYNC_OUTPUT_ENABLE,
  output logic             FIRST_CLOCK_DRIVER_ENABLE,
  output logic             SECOND_CLOCK_DRIVER_ENABLE,
  output logic             PLL_TWO_LOCK_DETECT_DISABLE,
  output logic             PLL_ONE_LOCK_DETECT_DISABLE,
  output logic [3:0]       MODE_CODE,
  output logic [4:0]       INPUT_MULTIPLE,
  output logic [5:0]       OUTPUT_MULTIPLE,
  output logic [3:0]       FIRST_OUTPUT_M,
  output logic [3:0]       SECOND_OUTPUT_M
);

  typedef logic [pllcm_pkg::DATA_W-1:0] pllcm_reg_t;

  typedef struct packed {
    logic [2:0]                                    ms_sync;
    logic                                          ms_lvl;
    logic [pllcm_pkg::REG_COUNT-1:0][pllcm_pkg::DATA_W-1:0] regs;
    logic                                          sdo;
    logic                                          sdo_oe;
    logic                                          master;
    logic                                          hs_rev;
    logic                                          t1e1;
    logic                                          pll1_en;
    logic                                          pll2_en;
    logic [pllcm_pkg::DATA_W-1:0]                  out_en;
    logic [3:0]                                    mode;
    logic [4:0]                                    n_mult;
    logic [5:0]                                    k_mult;
    logic [3:0]                                    m1;
    logic [3:0]                                    m2;
  } pllcm_top_s;

  logic       rst_meta_ff;
  logic       rst_n;
  pllcm_top_s s_ff;
  pllcm_top_s nxt_s;
  logic       wr_pulse;
  logic [2:0] wr_addr;
  pllcm_reg_t wdata;
  pllcm_reg_t rdata;
  logic       ser_sdo;
  logic       ser_sdo_oe;
  pllcm_reg_t mode_reg;
  pllcm_reg_t inmult_reg;

  // Multiplier code to M; upper bits win so every code maps to one value
  function automatic logic [3:0] mult_decode(input pllcm_reg_t code);
    logic [3:0] m;
    m = pllcm_pkg::MULT_X1;
    if (code[pllcm_pkg::BIT_M8_HI] || code[pllcm_pkg::BIT_M8_LO]) begin
      m = pllcm_pkg::MULT_X8;
    end else if (code[pllcm_pkg::BIT_M4]) begin
      m = pllcm_pkg::MULT_X4;
    end else if (code[pllcm_pkg::BIT_M2]) begin
      m = pllcm_pkg::MULT_X2;
    end
    return m;
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  pllcm_serial u_serial (
    .clk       (CLK),
    .rst_n     (rst_n),
    .scs_n_pin (SCS_N),
    .sclk_pin  (SCLK),
    .sdi_pin   (SDI),
    .rdata     (rdata),
    .wr_pulse  (wr_pulse),
    .addr      (wr_addr),
    .wdata     (wdata),
    .sdo       (ser_sdo),
    .sdo_oe    (ser_sdo_oe)
  );

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdata = pllcm_pkg::READ_ZERO;
    if (wr_addr < pllcm_pkg::REG_COUNT) begin
      rdata = s_ff.regs[wr_addr];
    end
  end

  assign mode_reg   = s_ff.regs[pllcm_pkg::ADDR_MODE_PLL1];
  assign inmult_reg = s_ff.regs[pllcm_pkg::ADDR_INMULT];

  // Register file and decode of the stored settings
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.ms_sync = {s_ff.ms_sync[1:0], MASTER_SELECT};
    if (s_ff.ms_sync[1] == s_ff.ms_sync[2]) begin
      nxt_s.ms_lvl = s_ff.ms_sync[2];
    end
    if (wr_pulse && (wr_addr < pllcm_pkg::REG_COUNT)) begin
      nxt_s.regs[wr_addr] = wdata;  // Holds until the next write here
    end
    nxt_s.sdo     = ser_sdo;
    nxt_s.sdo_oe  = ser_sdo_oe;
    nxt_s.master  = s_ff.ms_lvl;  // High select is master, REFERENCE_INPUT divided down
    nxt_s.mode    = mode_reg[pllcm_pkg::FIELD_MSB:pllcm_pkg::FIELD_LSB];
    // Reverse mode needs slave operation, so a master select blocks it
    nxt_s.hs_rev  = (nxt_s.mode == pllcm_pkg::MODE_HS_REVERSE) && !s_ff.ms_lvl;
    nxt_s.t1e1    = (nxt_s.mode == pllcm_pkg::MODE_T1_TO_E1) && s_ff.ms_lvl
                    && mode_reg[pllcm_pkg::BIT_PLL_EN];
    nxt_s.pll1_en = mode_reg[pllcm_pkg::BIT_PLL_EN];
    nxt_s.pll2_en = inmult_reg[pllcm_pkg::BIT_PLL_EN];
    nxt_s.out_en  = s_ff.regs[pllcm_pkg::ADDR_OUT_ENABLE];
    nxt_s.n_mult  = {1'b0, inmult_reg[pllcm_pkg::FIELD_MSB:pllcm_pkg::FIELD_LSB]} + 5'h01;
    nxt_s.k_mult  = {1'b0, s_ff.regs[pllcm_pkg::ADDR_OUT1_MULT]} + 6'h01;
    // Both outputs carry M x 2.048MHz only in reverse mode
    nxt_s.m1      = nxt_s.hs_rev ? mult_decode(s_ff.regs[pllcm_pkg::ADDR_OUT1_MULT])
                                 : pllcm_pkg::MULT_NONE;
    nxt_s.m2      = nxt_s.hs_rev ? mult_decode(s_ff.regs[pllcm_pkg::ADDR_OUT2_MULT])
                                 : pllcm_pkg::MULT_NONE;
  end

  // State register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{regs: {pllcm_pkg::REG_COUNT{pllcm_pkg::REG_RESET}}, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign SDO                         = s_ff.sdo;
  assign SDO_OE                      = s_ff.sdo_oe;
  assign MASTER_MODE                 = s_ff.master;
  assign REF_DIVIDE_ENABLE           = s_ff.master;
  assign HIGH_SPEED_REVERSE          = s_ff.hs_rev;
  assign T1_TO_E1_SETUP              = s_ff.t1e1;
  assign PLL_ONE_ENABLE              = s_ff.pll1_en;
  assign PLL_TWO_ENABLE              = s_ff.pll2_en;
  assign SYNC_OUTPUT_ENABLE          = s_ff.out_en[pllcm_pkg::BIT_SYNC_EN];
  assign FIRST_CLOCK_DRIVER_ENABLE   = s_ff.out_en[pllcm_pkg::BIT_FIRST_CLOCK_OUTPUT_EN];
  assign SECOND_CLOCK_DRIVER_ENABLE  = s_ff.out_en[pllcm_pkg::BIT_SECOND_CLOCK_OUTPUT_EN];
  assign PLL_TWO_LOCK_DETECT_DISABLE = s_ff.out_en[pllcm_pkg::BIT_LD2_DIS];
  assign PLL_ONE_LOCK_DETECT_DISABLE = s_ff.out_en[pllcm_pkg::BIT_LD1_DIS];
  assign MODE_CODE                   = s_ff.mode;
  assign INPUT_MULTIPLE              = s_ff.n_mult;
  assign OUTPUT_MULTIPLE             = s_ff.k_mult;
  assign FIRST_OUTPUT_M              = s_ff.m1;
  assign SECOND_OUTPUT_M             = s_ff.m2;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  // A write reaches the decoded outputs two cycles later
  chk_pll_one_en: assert property (wr_pulse && wr_addr == pllcm_pkg::ADDR_MODE_PLL1 |-> ##2 PLL_ONE_ENABLE == $past(wdata[0], 2))
    else $error("PLL one enable does not follow its register bit");
  chk_pll_two_en: assert property (wr_pulse && wr_addr == pllcm_pkg::ADDR_INMULT |-> ##2 PLL_TWO_ENABLE == $past(wdata[0], 2))
    else $error("PLL two enable does not follow its register bit");
  chk_master_mode: assert property ($rose(s_ff.ms_lvl) |=> MASTER_MODE && REF_DIVIDE_ENABLE)
    else $error("Master select high did not give master mode");
  chk_hs_reverse_sel: assert property (wr_pulse && wr_addr == pllcm_pkg::ADDR_MODE_PLL1 && wdata[4:1] == pllcm_pkg::MODE_HS_REVERSE
    && !s_ff.ms_lvl ##1 (!s_ff.ms_lvl)[*2] |-> HIGH_SPEED_REVERSE)
    else $error("Reverse mode code in slave did not select reverse mode");
  chk_hs_needs_slave: assert property (HIGH_SPEED_REVERSE |-> !$past(s_ff.ms_lvl))
    else $error("Reverse mode active while master selected");
  chk_first_m_code: assert property (HIGH_SPEED_REVERSE && $stable(s_ff.regs)
    && s_ff.regs[pllcm_pkg::ADDR_OUT1_MULT][4:1] == 4'h1 |-> FIRST_OUTPUT_M == pllcm_pkg::MULT_X2)
    else $error("First multiplier code 0001x did not give M of 2");
  chk_second_m_eight: assert property (HIGH_SPEED_REVERSE && $stable(s_ff.regs)
    && s_ff.regs[pllcm_pkg::ADDR_OUT2_MULT][4:3] != 2'h0 |-> SECOND_OUTPUT_M == pllcm_pkg::MULT_X8)
    else $error("Second multiplier high code did not give M of 8");
  chk_both_outputs: assert property (HIGH_SPEED_REVERSE |-> FIRST_OUTPUT_M != pllcm_pkg::MULT_NONE
    && SECOND_OUTPUT_M != pllcm_pkg::MULT_NONE)
    else $error("Reverse mode left an output without a multiplier");
  chk_out_enable_map: assert property (wr_pulse && wr_addr == pllcm_pkg::ADDR_OUT_ENABLE |-> ##2
    {SYNC_OUTPUT_ENABLE, FIRST_CLOCK_DRIVER_ENABLE, SECOND_CLOCK_DRIVER_ENABLE,
     PLL_TWO_LOCK_DETECT_DISABLE, PLL_ONE_LOCK_DETECT_DISABLE} == $past(wdata, 2))
    else $error("Output enable bits do not match the written value");
  chk_t1_setup: assert property (wr_pulse && wr_addr == pllcm_pkg::ADDR_MODE_PLL1 && wdata == 5'h05
    && s_ff.ms_lvl ##1 s_ff.ms_lvl |=> T1_TO_E1_SETUP && PLL_ONE_ENABLE)
    else $error("Code 00101 in master did not select the T1 setup");
  chk_n_multiple: assert property (wr_pulse && wr_addr == pllcm_pkg::ADDR_INMULT |-> ##2
    INPUT_MULTIPLE == {1'b0, $past(wdata[4:1], 2)} + 5'h01)
    else $error("Input multiple is not code plus one");
  chk_k_multiple: assert property (wr_pulse && wr_addr == pllcm_pkg::ADDR_OUT1_MULT && wdata == 5'h1F |-> ##2
    OUTPUT_MULTIPLE == 6'h20)
    else $error("Code 11111 did not give K of 32");
  chk_reg_holds: assert property (!wr_pulse |=> $stable(s_ff.regs))
    else $error("Register changed without a write");

  cov_hs_reverse: cover property (HIGH_SPEED_REVERSE && FIRST_OUTPUT_M == pllcm_pkg::MULT_X8);
  cov_t1_setup:   cover property (T1_TO_E1_SETUP && FIRST_CLOCK_DRIVER_ENABLE);
  cov_read_out:   cover property ($rose(SDO_OE) ##[1:200] $fell(SDO_OE));
  cov_both_plls:  cover property (PLL_ONE_ENABLE && PLL_TWO_ENABLE);

endmodule
`default_nettype wire

//--- include/pllcm_pkg.sv
// Purpose: Shared constants and types for the PLL clock mode configuration block
// Assumes: Five-bit command registers reached over a serial command port
// Notes:   Address map, field positions, mode codes and serial frame counts
package pllcm_pkg;

  // Register geometry
  localparam int unsigned DATA_W    = 5;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned REG_COUNT = 5;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_MODE_PLL1  = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_INMULT     = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_OUT1_MULT  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_OUT2_MULT  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_OUT_ENABLE = 3'h4;

  // Common reset value of every command register
  localparam logic [DATA_W-1:0] REG_RESET = 5'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 5'h00;

  // Field positions
  localparam int unsigned BIT_PLL_EN   = 0;  // D0 of the mode and input-multiple registers
  localparam int unsigned FIELD_MSB    = 4;  // D4..D1 hold the mode code or N-1
  localparam int unsigned FIELD_LSB    = 1;
  localparam int unsigned BIT_SYNC_EN  = 4;
  localparam int unsigned BIT_FIRST_CLOCK_OUTPUT_EN  = 3;
  localparam int unsigned BIT_SECOND_CLOCK_OUTPUT_EN  = 2;
  localparam int unsigned BIT_LD2_DIS  = 1;
  localparam int unsigned BIT_LD1_DIS  = 0;
  localparam int unsigned BIT_M8_HI    = 4;
  localparam int unsigned BIT_M8_LO    = 3;
  localparam int unsigned BIT_M4       = 2;
  localparam int unsigned BIT_M2       = 1;

  // Mode codes in D4..D1 of the mode register
  localparam logic [3:0] MODE_HS_REVERSE = 4'hD;
  localparam logic [3:0] MODE_T1_TO_E1   = 4'h2;

  // Output multiplier values in high-speed reverse mode
  localparam logic [3:0] MULT_NONE = 4'h0;
  localparam logic [3:0] MULT_X1   = 4'h1;
  localparam logic [3:0] MULT_X2   = 4'h2;
  localparam logic [3:0] MULT_X4   = 4'h4;
  localparam logic [3:0] MULT_X8   = 4'h8;

  // Serial frame: one read/write bit, three address bits, five data bits
  localparam logic [2:0] CMD_LAST  = 3'h3;
  localparam logic [2:0] DATA_LAST = 3'h4;

  typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_DATA, SER_DONE} pllcm_ser_e;

endpackage

//--- hw/pllcm_serial.sv
// Purpose: Serial command port slave for the command registers
// Assumes: Select low frames a transfer; data sampled on rising clock, driven on falling
// Notes:   Pins pass three flops and count once the second and third agree
`timescale 1ns/1ps
`default_nettype none
module pllcm_serial (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic                             scs_n_pin,
  input  wire logic                             sclk_pin,
  input  wire logic                             sdi_pin,
  input  wire logic [pllcm_pkg::DATA_W-1:0]     rdata,
  output logic                                  wr_pulse,
  output logic [pllcm_pkg::ADDR_W-1:0]          addr,
  output logic [pllcm_pkg::DATA_W-1:0]          wdata,
  output logic                                  sdo,
  output logic                                  sdo_oe
);

  typedef struct packed {
    logic [2:0]                       scs_sync;
    logic [2:0]                       sclk_sync;
    logic [2:0]                       sdi_sync;
    logic                             scs_lvl;
    logic                             sclk_lvl;
    logic                             sdi_lvl;
    pllcm_pkg::pllcm_ser_e            state;
    logic [2:0]                       cnt;
    logic                             rw;
    logic [pllcm_pkg::ADDR_W-1:0]     addr;
    logic [pllcm_pkg::DATA_W-1:0]     shreg;
    logic                             wr_pulse;
    logic                             sdo;
    logic                             sdo_oe;
  } pllcm_ser_s;

  // Select idles high, so its synchroniser starts deasserted
  localparam pllcm_ser_s SER_RESET = '{scs_sync: 3'h7, scs_lvl: 1'b1, state: pllcm_pkg::SER_IDLE, default: '0};

  pllcm_ser_s s_ff;
  pllcm_ser_s nxt_s;
  logic       rise;
  logic       fall;

  // Frame decode; the first sync flop feeds only the second
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.wr_pulse  = 1'b0;
    nxt_s.scs_sync  = {s_ff.scs_sync[1:0], scs_n_pin};
    nxt_s.sclk_sync = {s_ff.sclk_sync[1:0], sclk_pin};
    nxt_s.sdi_sync  = {s_ff.sdi_sync[1:0], sdi_pin};
    if (s_ff.scs_sync[1] == s_ff.scs_sync[2]) begin
      nxt_s.scs_lvl = s_ff.scs_sync[2];
    end
    if (s_ff.sclk_sync[1] == s_ff.sclk_sync[2]) begin
      nxt_s.sclk_lvl = s_ff.sclk_sync[2];
    end
    if (s_ff.sdi_sync[1] == s_ff.sdi_sync[2]) begin
      nxt_s.sdi_lvl = s_ff.sdi_sync[2];
    end
    rise = nxt_s.sclk_lvl & ~s_ff.sclk_lvl;
    fall = ~nxt_s.sclk_lvl & s_ff.sclk_lvl;
    if (nxt_s.scs_lvl) begin
      // Deselect ends any frame and releases the data-out pin
      nxt_s.state  = pllcm_pkg::SER_IDLE;
      nxt_s.cnt    = 3'h0;
      nxt_s.sdo_oe = 1'b0;
    end else begin
      case (s_ff.state)
        pllcm_pkg::SER_IDLE: begin
          nxt_s.state = pllcm_pkg::SER_CMD;
          nxt_s.cnt   = 3'h0;
        end
        pllcm_pkg::SER_CMD: begin
          if (rise) begin
            if (s_ff.cnt == 3'h0) begin
              nxt_s.rw = nxt_s.sdi_lvl;
            end else begin
              nxt_s.addr = {s_ff.addr[1:0], nxt_s.sdi_lvl};
            end
            nxt_s.cnt = s_ff.cnt + 3'h1;
            if (s_ff.cnt == pllcm_pkg::CMD_LAST) begin
              nxt_s.state = pllcm_pkg::SER_DATA;
              nxt_s.cnt   = 3'h0;
            end
          end
        end
        pllcm_pkg::SER_DATA: begin
          if (rise) begin
            if (!s_ff.rw) begin
              nxt_s.shreg = {s_ff.shreg[3:0], nxt_s.sdi_lvl};
            end
            nxt_s.cnt = s_ff.cnt + 3'h1;
            if (s_ff.cnt == pllcm_pkg::DATA_LAST) begin
              // Write lands only when the fifth data bit is in
              nxt_s.state    = pllcm_pkg::SER_DONE;
              nxt_s.wr_pulse = ~s_ff.rw;
            end
          end else if (fall && s_ff.rw) begin
            nxt_s.sdo_oe = 1'b1;
            if (!s_ff.sdo_oe) begin
              nxt_s.sdo   = rdata[4];
              nxt_s.shreg = {rdata[3:0], 1'b0};
            end else begin
              nxt_s.sdo   = s_ff.shreg[4];
              nxt_s.shreg = {s_ff.shreg[3:0], 1'b0};
            end
          end
        end
        pllcm_pkg::SER_DONE: begin
          nxt_s.cnt = s_ff.cnt;  // Extra clocks are ignored until deselect
        end
        default: begin
          nxt_s.state = pllcm_pkg::SER_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= SER_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wr_pulse = s_ff.wr_pulse;
  assign addr     = s_ff.addr;
  assign wdata    = s_ff.shreg;
  assign sdo      = s_ff.sdo;
  assign sdo_oe   = s_ff.sdo_oe;

endmodule
`default_nettype wire

//--- test/pllcm_host.sv
// Purpose: Host model that drives the serial command port
// Assumes: SCLK idles low and stands still between frames
// Notes:   SCLK stays high PH cycles and low at least 2*PH cycles, well above the sync filter
`timescale 1ns/1ps
`default_nettype none
module pllcm_host (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      scs_n,
  output logic      sclk,
  output logic      sdi
);
  localparam int PH = 8;

  // Idle levels from time zero
  initial begin
    scs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // One whole frame: R/W bit, address MSB first, data D4..D0
  task automatic xfer(input logic rw, input logic [2:0] a, input logic [4:0] d, output logic [4:0] q);
    logic [8:0] bits;
    bits = {rw, a, d};
    q = 5'h00;
    @(posedge clk);
    scs_n <= 1'b0;
    for (int i = 8; i >= 0; i--) begin
      repeat (PH) @(posedge clk);
      sdi <= bits[i];
      repeat (PH) @(posedge clk);
      sclk <= 1'b1;
      // Read bits are taken at rises five to nine
      if (i < 5) begin
        q[i] = sdo;
      end
      repeat (PH) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (PH) @(posedge clk);
    scs_n <= 1'b1;
    // Released line shows the inverse so a stale bit cannot pass
    sdi <= ~bits[0];
    repeat (PH) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- test/tb_pll_clock_mode_config.sv
// Purpose: Self-checking bench for the command register block
// Assumes: Host model speaks the serial frame; one 200 MHz clock
// Notes:   Settle waits cover the pin synchronisers and decode stage
`timescale 1ns/1ps
`default_nettype none
module tb_pll_clock_mode_config;
  logic      clk, resetn, master_sel;
  wire logic scs_n, sclk, sdi, sdo, sdo_oe, mmode, rdiv, hsr, t1, pll1, pll2;
  wire logic synce, clk1e, clk2e, ld2, ld1;
  wire logic [3:0] mode_code, m1, m2;
  wire logic [4:0] in_mult;
  wire logic [5:0] out_mult;
  wire logic [4:0] en_bits = {synce, clk1e, clk2e, ld2, ld1};
  // Undriven data-out floats to its pull-up, so a read that never drives cannot pass
  wire logic sdo_line = sdo_oe ? sdo : 1'b1;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h08, 5'h10};
  logic [3:0] mvals [8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8};

  pllcm_config DUT (.CLK(clk), .RESETN(resetn), .MASTER_SELECT(master_sel), .SCS_N(scs_n),
    .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .MASTER_MODE(mmode),
    .REF_DIVIDE_ENABLE(rdiv), .HIGH_SPEED_REVERSE(hsr), .T1_TO_E1_SETUP(t1),
    .PLL_ONE_ENABLE(pll1), .PLL_TWO_ENABLE(pll2), .SYNC_OUTPUT_ENABLE(synce),
    .FIRST_CLOCK_DRIVER_ENABLE(clk1e), .SECOND_CLOCK_DRIVER_ENABLE(clk2e),
    .PLL_TWO_LOCK_DETECT_DISABLE(ld2), .PLL_ONE_LOCK_DETECT_DISABLE(ld1),
    .MODE_CODE(mode_code), .INPUT_MULTIPLE(in_mult), .OUTPUT_MULTIPLE(out_mult),
    .FIRST_OUTPUT_M(m1), .SECOND_OUTPUT_M(m2));

  pllcm_host host (.clk(clk), .sdo(sdo_line), .scs_n(scs_n), .sclk(sclk), .sdi(sdi));

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard: a frame takes about 240 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Write then let the decoded outputs settle
  task automatic wr(input logic [2:0] a, input logic [4:0] d);
    logic [4:0] q;
    host.xfer(1'b0, a, d, q);
    repeat (4) @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [4:0] exp);
    logic [4:0] q;
    host.xfer(1'b1, a, 5'h00, q);
    chk("read data", 6'(exp), 6'(q));
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    master_sel = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (12) @(posedge clk);
    chk("pll one enable", 6'h00, 6'(pll1));
    for (int a = 0; a < 6; a++) begin
      rd(3'(a), 5'h00);
    end
    // Unmapped address takes no write and reads back zero
    wr(3'h5, 5'h1F);
    rd(3'h5, 5'h00);
    // Master path, T1 setup sequence
    master_sel <= 1'b1;
    repeat (10) @(posedge clk);
    chk("master mode", 6'h01, 6'(mmode));
    chk("reference divide", 6'h01, 6'(rdiv));
    wr(3'h0, 5'h05);
    wr(3'h1, 5'h00);
    wr(3'h2, 5'h1F);
    wr(3'h4, 5'h08);
    chk("t1 setup", 6'h01, 6'(t1));
    chk("pll one enable", 6'h01, 6'(pll1));
    chk("mode code", 6'h02, 6'(mode_code));
    chk("input multiple", 6'h01, 6'(in_mult));
    chk("output multiple", 6'h20, out_mult);
    chk("enables", 6'h08, 6'(en_bits));
    chk("first m", 6'h00, 6'(m1));
    rd(3'h4, 5'h08);
    wr(3'h0, 5'h1B);
    chk("reverse in master", 6'h00, 6'(hsr));
    // Slave path, high-speed reverse
    master_sel <= 1'b0;
    repeat (10) @(posedge clk);
    chk("master mode", 6'h00, 6'(mmode));
    chk("reverse", 6'h01, 6'(hsr));
    wr(3'h1, 5'h01);
    chk("pll two enable", 6'h01, 6'(pll2));
    wr(3'h0, 5'h1A);
    chk("pll one enable", 6'h00, 6'(pll1));
    chk("reverse", 6'h01, 6'(hsr));
    // Every multiplier code class on both outputs
    for (int i = 0; i < 8; i++) begin
      wr(3'h2, codes[i]);
      wr(3'h3, codes[7-i]);
      chk("first m", 6'(mvals[i]), 6'(m1));
      chk("second m", 6'(mvals[7-i]), 6'(m2));
      chk("output multiple", 6'(codes[i]) + 6'h01, out_mult);
    end
    // One enable bit at a time
    for (int b = 0; b < 5; b++) begin
      wr(3'h4, 5'(1 << b));
      chk("enables", 6'(1 << b), 6'(en_bits));
      rd(3'h4, 5'(1 << b));
    end
    wr(3'h1, 5'h00);
    chk("pll two enable", 6'h00, 6'(pll2));
    print_verdict();
  end
endmodule
`default_nettype wire
